// *** core/efs_oc_detect.sv ***
// Overcurrent comparator with hysteresis and clamped limit reference
`timescale 1ns/1ps
module efs_oc_detect #(
  parameter int unsigned W = 12
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] sense,
  input wire logic [W-1:0] limit_reference,
  output logic oc_flag,
  output logic over_limit
);
  logic [W-1:0] ref_clamped;
  logic next_oc_flag;
  logic next_over_limit;

  function automatic logic [W+6:0] pct(input logic [W-1:0] v, input int unsigned p);
    pct = (W+7)'(v) * (W+7)'(p);
  endfunction

  always_comb begin
    ref_clamped = (limit_reference > efs_pkg::LIMIT_REF_MAX) ?
      efs_pkg::LIMIT_REF_MAX : limit_reference;
    next_over_limit = sense > ref_clamped;
    next_oc_flag = oc_flag;
    if (pct(sense, 100) > pct(ref_clamped, efs_pkg::OC_SET_PCT)) begin
      next_oc_flag = 1'b1;
    end else if (pct(sense, 100) < pct(ref_clamped, efs_pkg::OC_CLR_PCT)) begin
      next_oc_flag = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      oc_flag <= 1'b0;
      over_limit <= 1'b0;
    end else begin
      oc_flag <= next_oc_flag;
      over_limit <= next_over_limit;
    end
  end

  a_oc_hyst_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (oc_flag && pct(sense, 100) >= pct(ref_clamped, efs_pkg::OC_CLR_PCT))
      |=> oc_flag)
    else $error("Overcurrent flag released above release level");
endmodule

// *** core/efs_pkg.sv ***
// Package of constants and carrier types for the fuse supervisor
package efs_pkg;

  // ******************************************************************
  // Timing
  // ******************************************************************
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned LIMIT_TIME_US = 250;
  localparam int unsigned LIMIT_CYCLES = (LIMIT_TIME_US * (CLK_HZ / 1_000_000));
  localparam int unsigned START_TIME_MS = 200;
  localparam int unsigned START_CYCLES = START_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned RETRY_TIME_MS = 1000;
  localparam int unsigned RETRY_CYCLES = RETRY_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned TIMER_W = 26;

  // ******************************************************************
  // Levels and widths
  // ******************************************************************
  localparam int unsigned SENSE_W = 12;
  localparam logic [11:0] LIMIT_REF_MAX = 12'hc00;
  localparam int unsigned OC_SET_PCT = 85;
  localparam int unsigned OC_CLR_PCT = 75;

  // ******************************************************************
  // Carrier types
  // ******************************************************************
  typedef struct packed {
    logic short_circuit;
    logic over_temp;
    logic gate_leak;
    logic gate_short;
    logic out_low;
    logic pump_error;
    logic pulldown_error;
  } efs_diag_t;

  typedef struct packed {
    logic undervoltage_lockout_ok;
    logic enable_discharge_input;
    logic out_reached;
    logic ds_short;
    logic ds_ok;
  } efs_supply_t;

  typedef struct packed {
    logic [11:0] sense;
    logic [11:0] limit_reference;
  } efs_sense_t;

  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_START = 5'h02,
    ST_ON = 5'h04,
    ST_FAULT = 5'h08,
    ST_RETRY = 5'h10
  } efs_state_t;

endpackage

// *** core/efs_supervisor.sv ***
// Fault supervisor top: timers, fault latch, open-drain status flags
`timescale 1ns/1ps
module efs_supervisor #(
  parameter int unsigned LIMIT_CYCLES = efs_pkg::LIMIT_CYCLES,
  parameter int unsigned START_CYCLES = efs_pkg::START_CYCLES,
  parameter int unsigned RETRY_CYCLES = efs_pkg::RETRY_CYCLES,
  parameter bit AUTO_RETRY = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire efs_pkg::efs_sense_t sense_in,
  input wire efs_pkg::efs_diag_t diag_in,
  input wire efs_pkg::efs_supply_t supply_in,
  output logic switch_on,
  output logic current_clamp,
  output logic ss_discharge,
  output logic overcurrent_flag_n_o,
  output logic overcurrent_flag_n_oe,
  output logic gate_fault_flag_n_o,
  output logic gate_fault_flag_n_oe,
  output logic fault_latched
);
  // ******************************************************************
  // Input synchronisation
  // ******************************************************************
  efs_pkg::efs_diag_t diag;
  efs_pkg::efs_supply_t sup;
  efs_pkg::efs_sense_t sense_s;
  logic oc_flag;
  logic over_limit;

  efs_sync #(.W($bits(efs_pkg::efs_diag_t) + $bits(efs_pkg::efs_supply_t))) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .din({diag_in, supply_in}),
    .dout({diag, sup})
  );

  // Sense words are treated as quasi-static converter results
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sense_s <= '0;
    end else begin
      sense_s <= sense_in;
    end
  end

  efs_oc_detect #(.W(efs_pkg::SENSE_W)) u_oc (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .sense(sense_s.sense),
    .limit_reference(sense_s.limit_reference),
    .oc_flag(oc_flag),
    .over_limit(over_limit)
  );

  // ******************************************************************
  // Control state
  // ******************************************************************
  efs_pkg::efs_state_t state;
  efs_pkg::efs_state_t next_state;
  logic [efs_pkg::TIMER_W-1:0] lim_cnt;
  logic [efs_pkg::TIMER_W-1:0] next_lim_cnt;
  logic [efs_pkg::TIMER_W-1:0] tmr;
  logic [efs_pkg::TIMER_W-1:0] next_tmr;
  logic next_fault_latched;
  logic next_sc_seen;
  logic sc_seen;
  logic next_switch_on;
  logic next_clamp;
  logic next_ss_dis;
  logic next_oc_n_oe;
  logic next_gf_n_oe;
  logic fault_now;
  logic diag_fault;
  logic limit_expired;
  logic ds_hold;
  logic next_ds_hold;

  always_comb begin
    diag_fault = diag.gate_leak | diag.gate_short | diag.pump_error |
      diag.pulldown_error;
    limit_expired = over_limit &&
      (lim_cnt >= efs_pkg::TIMER_W'(LIMIT_CYCLES - 1));
    next_lim_cnt = (over_limit && state == efs_pkg::ST_ON && !limit_expired) ?
      lim_cnt + 1'b1 : '0;
    next_state = state;
    next_tmr = tmr;
    next_fault_latched = fault_latched;
    next_sc_seen = sc_seen;
    fault_now = 1'b0;
    case (state)
      efs_pkg::ST_OFF: begin
        next_tmr = '0;
        if (sup.enable_discharge_input && !sup.ds_short && !ds_hold && !diag.over_temp) begin
          next_state = efs_pkg::ST_START;
        end
      end
      efs_pkg::ST_START: begin
        next_tmr = tmr + 1'b1;
        if (diag.short_circuit || diag.over_temp || diag_fault) begin
          fault_now = 1'b1;
        end else if (tmr >= efs_pkg::TIMER_W'(START_CYCLES - 1)) begin
          fault_now = 1'b1;
        end else if (!sup.enable_discharge_input) begin
          next_state = efs_pkg::ST_OFF;
        end else if (sup.out_reached) begin
          next_state = efs_pkg::ST_ON;
        end
      end
      efs_pkg::ST_ON: begin
        if (diag.over_temp || diag.short_circuit || limit_expired || diag_fault ||
            diag.out_low) begin
          fault_now = 1'b1;
        end else if (!sup.enable_discharge_input) begin
          next_state = efs_pkg::ST_OFF;
        end
      end
      efs_pkg::ST_FAULT: begin
        next_tmr = '0;
        if (AUTO_RETRY) begin
          next_state = efs_pkg::ST_RETRY;
        end
      end
      efs_pkg::ST_RETRY: begin
        next_tmr = tmr + 1'b1;
        if (tmr >= efs_pkg::TIMER_W'(RETRY_CYCLES - 1) && !diag.over_temp) begin
          next_state = efs_pkg::ST_START;
          next_fault_latched = 1'b0;
          next_sc_seen = 1'b0;
          next_tmr = '0;
        end
      end
      default: next_state = efs_pkg::ST_OFF;
    endcase
    if (fault_now) begin
      next_state = efs_pkg::ST_FAULT;
      next_fault_latched = 1'b1;
      next_tmr = '0;
      if (diag.short_circuit) begin
        next_sc_seen = 1'b1;
      end
    end
    if (diag.over_temp && state != efs_pkg::ST_FAULT && state != efs_pkg::ST_RETRY &&
        sup.undervoltage_lockout_ok) begin
      next_state = efs_pkg::ST_FAULT;
      next_fault_latched = 1'b1;
    end
    if (!sup.undervoltage_lockout_ok) begin
      next_state = efs_pkg::ST_OFF;
      next_fault_latched = 1'b0;
      next_sc_seen = 1'b0;
      next_tmr = '0;
    end
    next_switch_on = (next_state == efs_pkg::ST_START || next_state == efs_pkg::ST_ON);
    next_clamp = next_switch_on && over_limit;
    next_ss_dis = !next_switch_on;
    next_oc_n_oe = oc_flag || next_sc_seen;
    next_gf_n_oe = !sup.undervoltage_lockout_ok || next_fault_latched ||
      (next_state == efs_pkg::ST_OFF && sup.ds_short);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= efs_pkg::ST_OFF;
      lim_cnt <= '0;
      tmr <= '0;
      fault_latched <= 1'b0;
      sc_seen <= 1'b0;
      switch_on <= 1'b0;
      current_clamp <= 1'b0;
      ss_discharge <= 1'b1;
      overcurrent_flag_n_oe <= 1'b0;
      gate_fault_flag_n_oe <= 1'b1;
    end else begin
      state <= next_state;
      lim_cnt <= next_lim_cnt;
      tmr <= next_tmr;
      fault_latched <= next_fault_latched;
      sc_seen <= next_sc_seen;
      switch_on <= next_switch_on;
      current_clamp <= next_clamp;
      ss_discharge <= next_ss_dis;
      overcurrent_flag_n_oe <= next_oc_n_oe;
      gate_fault_flag_n_oe <= next_gf_n_oe;
    end
  end

  // ******************************************************************
  // Drain-source short hold
  // ******************************************************************
  always_comb begin
    next_ds_hold = ds_hold;
    if (state == efs_pkg::ST_OFF && !sup.enable_discharge_input && sup.ds_short) begin
      next_ds_hold = 1'b1;
    end else if (sup.ds_ok) begin
      next_ds_hold = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ds_hold <= 1'b0;
    end else begin
      ds_hold <= next_ds_hold;
    end
  end

  // Open-drain pins only ever pull low
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      overcurrent_flag_n_o <= 1'b0;
      gate_fault_flag_n_o <= 1'b0;
    end else begin
      overcurrent_flag_n_o <= 1'b0;
      gate_fault_flag_n_o <= 1'b0;
    end
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  a_temp_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (diag.over_temp && sup.undervoltage_lockout_ok) |=> !switch_on)
    else $error("Switch still on after over-temperature");
  a_undervoltage_lockout_flag: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !sup.undervoltage_lockout_ok |=> gate_fault_flag_n_oe)
    else $error("Gate-ok not low under lockout");
  a_sc_flag: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (diag.short_circuit && switch_on && sup.undervoltage_lockout_ok) |=>
      (!switch_on && overcurrent_flag_n_oe))
    else $error("Short circuit not handled");
  a_limit_time: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (lim_cnt == efs_pkg::TIMER_W'(LIMIT_CYCLES - 1) && over_limit && state == efs_pkg::ST_ON
      && sup.undervoltage_lockout_ok) |=> (state == efs_pkg::ST_FAULT))
    else $error("Limit timer expiry missed");
  a_fault_gok: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fault_latched |-> (gate_fault_flag_n_oe && ss_discharge))
    else $error("Gate-ok released with stored fault");
  a_latch_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!AUTO_RETRY && state == efs_pkg::ST_FAULT && sup.undervoltage_lockout_ok) |=>
      (state == efs_pkg::ST_FAULT || !sup.undervoltage_lockout_ok))
    else $error("Latch-off variant left fault state");
  a_enable_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state == efs_pkg::ST_ON && !sup.enable_discharge_input && !fault_now &&
      !diag.over_temp && sup.undervoltage_lockout_ok && !fault_latched) |=> !fault_latched)
    else $error("Commanded shutdown marked as fault");
  a_ds_block: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state == efs_pkg::ST_OFF && sup.ds_short) |=> state != efs_pkg::ST_START)
    else $error("Startup not blocked by drain-source short");
  a_retry_start: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state == efs_pkg::ST_RETRY && tmr < efs_pkg::TIMER_W'(RETRY_CYCLES - 1)) |=>
      state != efs_pkg::ST_START)
    else $error("Retry started early");
  a_clamp_on: assert property (@(posedge sys_clk) disable iff (!rst_b)
    current_clamp |-> switch_on)
    else $error("Current clamp active with switch off");
  a_oc_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!oc_flag && !sc_seen && !diag.short_circuit) |=> !overcurrent_flag_n_oe)
    else $error("Overcurrent flag pulled without overload");
  a_start_time: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state == efs_pkg::ST_START && tmr == efs_pkg::TIMER_W'(START_CYCLES - 1) &&
      sup.undervoltage_lockout_ok) |=> (state == efs_pkg::ST_FAULT))
    else $error("Startup timeout missed");
  a_diag_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (diag_fault && switch_on && sup.undervoltage_lockout_ok) |=> (!switch_on && fault_latched))
    else $error("Diagnostic fault did not switch off");
  a_gate_release: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state == efs_pkg::ST_OFF && sup.undervoltage_lockout_ok && !sup.ds_short && !fault_latched &&
      !diag.over_temp) |=> !gate_fault_flag_n_oe)
    else $error("Gate-ok held low after lockout cleared");
  a_fault_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state == efs_pkg::ST_FAULT && sup.undervoltage_lockout_ok) |=> !switch_on)
    else $error("Switch re-enabled after fault");
  a_lockout_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !sup.undervoltage_lockout_ok |=> (state == efs_pkg::ST_OFF && !fault_latched && !switch_on))
    else $error("Lockout did not clear fault state");
  a_retry_go: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (AUTO_RETRY && state == efs_pkg::ST_FAULT && sup.undervoltage_lockout_ok) |=>
      (state == efs_pkg::ST_RETRY))
    else $error("Auto-retry variant stuck in fault state");
  a_ds_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state == efs_pkg::ST_OFF && ds_hold) |=> (state != efs_pkg::ST_START))
    else $error("Startup not held until output discharged");
  a_retry_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state == efs_pkg::ST_START) |-> !fault_latched)
    else $error("Fault still stored after restart");
endmodule

// *** core/efs_sync.sv ***
// Two-stage synchroniser for a bundle of comparator levels
`timescale 1ns/1ps
module efs_sync #(
  parameter int unsigned W = 1
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_dout;

  always_comb begin
    next_stage1 = din;
    next_dout = stage1;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= next_stage1;
      dout <= next_dout;
    end
  end
endmodule

// *** tb/efs_flag_monitor.sv ***
// System controller side: pulled-up open-drain status lines
`timescale 1ns/1ps
module efs_flag_monitor (
  input wire logic oc_o,
  input wire logic oc_oe,
  input wire logic gate_o,
  input wire logic gate_oe,
  output logic oc_pin,
  output logic gate_pin
);
  // ****************************************
  // Pull-up resistors on both lines
  // ****************************************
  assign oc_pin = oc_oe ? oc_o : 1'b1;
  assign gate_pin = gate_oe ? gate_o : 1'b1;
endmodule

// *** tb/efs_supervisor_test.sv ***
// Self-checking bench for the fuse supervisor, latch and retry variants
`timescale 1ns/1ps
module efs_supervisor_test;
  localparam int LIM = 8;
  localparam int STA = 40;
  localparam int RET = 50;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  efs_pkg::efs_sense_t sense_in = '0;
  efs_pkg::efs_diag_t diag_in = '0;
  efs_pkg::efs_supply_t supply_in = '0;
  logic sw, clamp, ssd, oc_o, oc_oe, gk_o, gk_oe, flt, oc_pin, gk_pin;
  logic r_sw, r_ssd, r_oc_o, r_oc_oe, r_gk_o, r_gk_oe, r_flt;
  logic [11:0] hs [4] = '{12'd85, 12'd86, 12'd75, 12'd74};
  logic hx [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic [11:0] r;
  int failures = 0;
  int checks_done = 0;
  int rnd;

  always #20 sys_clk = ~sys_clk;

  efs_supervisor #(.LIMIT_CYCLES(LIM), .START_CYCLES(STA), .RETRY_CYCLES(RET),
    .AUTO_RETRY(1'b0)) u_efs_supervisor (.sys_clk(sys_clk), .rst_b(rst_b),
    .sense_in(sense_in), .diag_in(diag_in), .supply_in(supply_in), .switch_on(sw),
    .current_clamp(clamp), .ss_discharge(ssd), .overcurrent_flag_n_o(oc_o),
    .overcurrent_flag_n_oe(oc_oe), .gate_fault_flag_n_o(gk_o),
    .gate_fault_flag_n_oe(gk_oe), .fault_latched(flt));

  efs_supervisor #(.LIMIT_CYCLES(LIM), .START_CYCLES(STA), .RETRY_CYCLES(RET),
    .AUTO_RETRY(1'b1)) u_efs_supervisor_retry (.sys_clk(sys_clk), .rst_b(rst_b),
    .sense_in(sense_in), .diag_in(diag_in), .supply_in(supply_in), .switch_on(r_sw),
    .current_clamp(), .ss_discharge(r_ssd), .overcurrent_flag_n_o(r_oc_o),
    .overcurrent_flag_n_oe(r_oc_oe), .gate_fault_flag_n_o(r_gk_o),
    .gate_fault_flag_n_oe(r_gk_oe), .fault_latched(r_flt));

  efs_flag_monitor u_efs_flag_monitor (.oc_o(oc_o), .oc_oe(oc_oe), .gate_o(gk_o),
    .gate_oe(gk_oe), .oc_pin(oc_pin), .gate_pin(gk_pin));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic sig(input int sel);
    case (sel)
      0: return sw;
      1: return gk_pin;
      2: return oc_pin;
      3: return clamp;
      4: return flt;
      5: return r_sw;
      default: return ssd;
    endcase
  endfunction

  function automatic logic [11:0] pct(input logic [11:0] v, input int p);
    return 12'((int'(v) * p) / 100);
  endfunction

  task automatic end_of_test();
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic await(input int sel, input logic val, input int max);
    int n;
    n = 0;
    while (sig(sel) !== val && n < max) begin
      @(negedge sys_clk);
      n++;
    end
    chk(sig(sel), val);
    if (sig(sel) !== val) end_of_test();
  endtask

  task automatic hold(input int sel, input logic val, input int n);
    repeat (n) begin
      @(negedge sys_clk);
      chk(sig(sel), val);
    end
  endtask

  task automatic step(input logic [11:0] s, input logic exp);
    sense_in.sense = s;
    repeat (6) @(negedge sys_clk);
    hold(2, exp, 4);
  endtask

  task automatic start_on();
    supply_in.enable_discharge_input = 1'b1;
    await(0, 1'b1, 10);
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic recover();
    supply_in.undervoltage_lockout_ok = 1'b0;
    supply_in.enable_discharge_input = 1'b0;
    await(1, 1'b0, 8);
    await(4, 1'b0, 8);
    diag_in = '0;
    sense_in.sense = '0;
    supply_in.undervoltage_lockout_ok = 1'b1;
    await(1, 1'b1, 8);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rnd = $urandom(32'h88ca);
    supply_in.ds_ok = 1'b1;
    supply_in.out_reached = 1'b1;
    supply_in.undervoltage_lockout_ok = 1'b1;
    sense_in.limit_reference = 12'h064;
    repeat (16) @(negedge sys_clk);
    rst_b = 1'b1;
    await(1, 1'b1, 8);
    hold(0, 1'b0, 4);
    start_on();
    foreach (hs[i]) step(hs[i], hx[i]);
    repeat (4) begin
      r = 12'h400 + 12'($urandom % 2048);
      sense_in.limit_reference = r;
      step(pct(r, 80), 1'b1);
      step(pct(r, 95), 1'b0);
      step(pct(r, 80), 1'b0);
      step(pct(r, 70), 1'b1);
    end
    chk(sw, 1'b1);
    sense_in.limit_reference = 12'hfff;
    sense_in.sense = 12'hc10;
    await(3, 1'b1, 8);
    hold(0, 1'b1, LIM - 3);
    await(0, 1'b0, 12);
    await(1, 1'b0, 4);
    chk(ssd, 1'b1);
    repeat (3) begin
      hold(5, 1'b0, RET);
      await(5, 1'b1, 4);
      chk(r_flt, 1'b0);
      await(5, 1'b0, LIM + 20);
      chk(r_gk_oe, 1'b1);
      chk(r_ssd, 1'b1);
      chk(r_oc_oe, 1'b1);
      chk(r_flt, 1'b1);
    end
    chk(r_oc_o | r_gk_o, 1'b0);
    chk(sw, 1'b0);
    supply_in.enable_discharge_input = 1'b0;
    repeat (4) @(negedge sys_clk);
    supply_in.enable_discharge_input = 1'b1;
    hold(0, 1'b0, 10);
    recover();
    for (int i = 0; i < 7; i++) begin
      start_on();
      diag_in = 7'(1 << i);
      await(0, 1'b0, 8);
      await(1, 1'b0, 8);
      await(4, 1'b1, 4);
      chk(ssd, 1'b1);
      if (i == 6) await(2, 1'b0, 4);
      recover();
    end
    supply_in.out_reached = 1'b0;
    supply_in.enable_discharge_input = 1'b1;
    await(0, 1'b1, 10);
    hold(1, 1'b1, STA - 10);
    await(1, 1'b0, 30);
    await(0, 1'b0, 4);
    recover();
    supply_in.out_reached = 1'b1;
    start_on();
    supply_in.enable_discharge_input = 1'b0;
    await(0, 1'b0, 8);
    hold(1, 1'b1, 8);
    supply_in.ds_short = 1'b1;
    supply_in.ds_ok = 1'b0;
    repeat (4) @(negedge sys_clk);
    supply_in.enable_discharge_input = 1'b1;
    hold(0, 1'b0, 10);
    supply_in.ds_short = 1'b0;
    supply_in.ds_ok = 1'b1;
    await(0, 1'b1, 10);
    end_of_test();
  end
endmodule
